// >>> hdl/bmu_pkg.sv
// Package of operation codes and constants for the CPU bit manipulation unit.
package bmu_pkg;

    localparam int unsigned DATA_W = 8;
    localparam int unsigned IDX_W  = 3;
    localparam int unsigned OP_W   = 4;

    localparam logic [DATA_W-1:0] RESET_RESULT = 8'h00;
    localparam logic              RESET_FLAG   = 1'b0;

    typedef enum logic [OP_W-1:0] {
        BIT_SET_OP              = 4'h0,
        BIT_CLEAR_OP            = 4'h1,
        BIT_INVERT_OP           = 4'h2,
        BIT_TEST_OP             = 4'h3,
        BIT_AND_CARRY_OP        = 4'h4,
        BIT_INV_AND_CARRY_OP    = 4'h5,
        BIT_OR_CARRY_OP         = 4'h6,
        BIT_INV_OR_CARRY_OP     = 4'h7,
        BIT_XOR_CARRY_OP        = 4'h8,
        BIT_INV_XOR_CARRY_OP    = 4'h9,
        BIT_LOAD_CARRY_OP       = 4'ha,
        BIT_INV_LOAD_CARRY_OP   = 4'hb,
        CARRY_STORE_BIT_OP      = 4'hc,
        INV_CARRY_STORE_BIT_OP  = 4'hd
    } bmu_op_e;

endpackage

// >>> hdl/bmu_core.sv
// One-cycle execution datapath for single-bit CPU instructions.
`timescale 1ns/1ps
module bmu_core
    import bmu_pkg::*;
(
    input  wire logic              I_CORE_CLK,    // Core clock, 20 MHz.
    input  wire logic              I_RST_N,       // Asynchronous reset, active low.
    input  wire logic              I_START,       // Pulse: execute one operation.
    input  wire logic [OP_W-1:0]   I_OP,          // Operation code (bmu_op_e).
    input  wire logic [DATA_W-1:0] I_OPERAND,     // Byte read from register or memory.
    input  wire logic              I_IDX_FROM_REG,// 1: index from register, 0: immediate.
    input  wire logic [IDX_W-1:0]  I_IMM_IDX,     // 3-bit immediate bit index.
    input  wire logic [DATA_W-1:0] I_IDX_REG,     // General register supplying the index.
    input  wire logic              I_CARRY,       // Current carry flag.
    output logic      [DATA_W-1:0] O_RESULT,      // Byte to write back.
    output logic                   O_WRITE,       // Pulse: write O_RESULT back.
    output logic                   O_CARRY,       // Carry flag value.
    output logic                   O_CARRY_WE,    // Pulse: load O_CARRY into flag.
    output logic                   O_ZERO,        // Zero flag value.
    output logic                   O_ZERO_WE,     // Pulse: load O_ZERO into flag.
    output logic                   O_DONE,        // Pulse: results valid.
    output logic                   O_ILLEGAL      // Pulse: unknown op or bad index source.
);

    // Decoded operation and the classes it falls into.
    bmu_op_e           op;
    logic              known_op;
    logic              inv_op;
    logic              bad_src;
    logic              accept;
    logic              set_op;
    logic              clear_op;
    logic              invert_op;
    logic              test_op;
    logic              store_op;
    logic              modify_op;
    logic              carry_op;

    // Bit selection.
    logic [IDX_W-1:0]  idx;
    logic [DATA_W-1:0] hit;
    logic              sel_bit;
    logic              store_val;

    // Values loaded into the output registers at the next edge.
    logic [DATA_W-1:0] next_result;
    logic              next_carry;
    logic              next_zero;
    logic              next_write;
    logic              next_carry_we;
    logic              next_zero_we;
    logic              next_done;
    logic              next_illegal;

    assign op = bmu_op_e'(I_OP);

    // Codes past the last operation stay unknown and are refused rather than aliased.
    always_comb begin
        known_op  = 1'h0;
        set_op    = 1'h0;
        clear_op  = 1'h0;
        invert_op = 1'h0;
        test_op   = 1'h0;
        store_op  = 1'h0;
        modify_op = 1'h0;
        carry_op  = 1'h0;
        inv_op    = 1'h0;
        unique case (op)
            BIT_SET_OP: begin
                known_op  = 1'h1;
                set_op    = 1'h1;
                modify_op = 1'h1;
            end
            BIT_CLEAR_OP: begin
                known_op  = 1'h1;
                clear_op  = 1'h1;
                modify_op = 1'h1;
            end
            BIT_INVERT_OP: begin
                known_op  = 1'h1;
                invert_op = 1'h1;
                modify_op = 1'h1;
            end
            BIT_TEST_OP: begin
                known_op = 1'h1;
                test_op  = 1'h1;
            end
            BIT_AND_CARRY_OP: begin
                known_op = 1'h1;
                carry_op = 1'h1;
            end
            BIT_INV_AND_CARRY_OP: begin
                known_op = 1'h1;
                carry_op = 1'h1;
                inv_op   = 1'h1;
            end
            BIT_OR_CARRY_OP: begin
                known_op = 1'h1;
                carry_op = 1'h1;
            end
            BIT_INV_OR_CARRY_OP: begin
                known_op = 1'h1;
                carry_op = 1'h1;
                inv_op   = 1'h1;
            end
            BIT_XOR_CARRY_OP: begin
                known_op = 1'h1;
                carry_op = 1'h1;
            end
            BIT_INV_XOR_CARRY_OP: begin
                known_op = 1'h1;
                carry_op = 1'h1;
                inv_op   = 1'h1;
            end
            BIT_LOAD_CARRY_OP: begin
                known_op = 1'h1;
                carry_op = 1'h1;
            end
            BIT_INV_LOAD_CARRY_OP: begin
                known_op = 1'h1;
                carry_op = 1'h1;
                inv_op   = 1'h1;
            end
            CARRY_STORE_BIT_OP: begin
                known_op  = 1'h1;
                store_op  = 1'h1;
                modify_op = 1'h1;
            end
            INV_CARRY_STORE_BIT_OP: begin
                known_op  = 1'h1;
                store_op  = 1'h1;
                modify_op = 1'h1;
                inv_op    = 1'h1;
            end
            default: begin
                known_op = 1'h0;
            end
        endcase
    end

    // Inverted variants carry no register index field in their encoding.
    assign bad_src = inv_op && I_IDX_FROM_REG;

    // An operation is carried out only when it is known and its index source is allowed.
    assign accept = I_START && known_op && !bad_src;

    // Only the low three bits of the index register count; upper bits are ignored.
    assign idx     = I_IDX_FROM_REG ? I_IDX_REG[IDX_W-1:0] : I_IMM_IDX;
    assign sel_bit = I_OPERAND[idx];

    // The stored value is the carry itself or its inverse.
    always_comb begin
        if (op == INV_CARRY_STORE_BIT_OP) begin
            store_val = ~I_CARRY;
        end else begin
            store_val = I_CARRY;
        end
    end

    // One slice per bit. A slice that the index does not select passes its bit through,
    // so the other seven bits of a rewritten byte always keep their value.
    for (genvar b = 0; b < DATA_W; b++) begin : g_bit
        logic slice;

        assign hit[b] = (idx == IDX_W'(b));

        always_comb begin
            slice = I_OPERAND[b];
            if (hit[b]) begin
                unique case (op)
                    BIT_SET_OP: begin
                        slice = 1'h1;
                    end
                    BIT_CLEAR_OP: begin
                        slice = 1'h0;
                    end
                    BIT_INVERT_OP: begin
                        slice = ~I_OPERAND[b];
                    end
                    CARRY_STORE_BIT_OP, INV_CARRY_STORE_BIT_OP: begin
                        slice = store_val;
                    end
                    default: begin
                        slice = I_OPERAND[b];
                    end
                endcase
            end
        end

        assign next_result[b] = slice;
    end

    // Carry combine and load; operations that leave the carry alone pass it through.
    always_comb begin
        next_carry = I_CARRY;
        unique case (op)
            BIT_AND_CARRY_OP: begin
                next_carry = I_CARRY & sel_bit;
            end
            BIT_INV_AND_CARRY_OP: begin
                next_carry = I_CARRY & ~sel_bit;
            end
            BIT_OR_CARRY_OP: begin
                next_carry = I_CARRY | sel_bit;
            end
            BIT_INV_OR_CARRY_OP: begin
                next_carry = I_CARRY | ~sel_bit;
            end
            BIT_XOR_CARRY_OP: begin
                next_carry = I_CARRY ^ sel_bit;
            end
            BIT_INV_XOR_CARRY_OP: begin
                next_carry = I_CARRY ^ ~sel_bit;
            end
            BIT_LOAD_CARRY_OP: begin
                next_carry = sel_bit;
            end
            BIT_INV_LOAD_CARRY_OP: begin
                next_carry = ~sel_bit;
            end
            default: begin
                next_carry = I_CARRY;
            end
        endcase
    end

    // The zero flag reports an empty selected bit.
    assign next_zero = ~sel_bit;

    // A refused operation changes nothing, so its write strobes stay low; O_DONE and O_ILLEGAL still pulse.
    assign next_write    = accept && modify_op;
    assign next_carry_we = accept && carry_op;
    assign next_zero_we  = accept && test_op;
    assign next_done     = I_START;
    assign next_illegal  = I_START && (!known_op || bad_src);

    // Data outputs hold their last value between operations.
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_RESULT <= RESET_RESULT;
        end else if (accept) begin
            O_RESULT <= next_result;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_CARRY <= RESET_FLAG;
        end else if (accept) begin
            O_CARRY <= next_carry;
        end
    end

    // The zero flag moves only on a test; other operations leave it as it was.
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_ZERO <= RESET_FLAG;
        end else if (next_zero_we) begin
            O_ZERO <= next_zero;
        end
    end

    // Each strobe stands for exactly one cycle after the edge that took the request.
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_WRITE <= 1'h0;
        end else begin
            O_WRITE <= next_write;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_CARRY_WE <= 1'h0;
        end else begin
            O_CARRY_WE <= next_carry_we;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_ZERO_WE <= 1'h0;
        end else begin
            O_ZERO_WE <= next_zero_we;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_DONE <= 1'h0;
        end else begin
            O_DONE <= next_done;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_ILLEGAL <= 1'h0;
        end else begin
            O_ILLEGAL <= next_illegal;
        end
    end

endmodule // bmu_core

// >>> sim/bmu_core_asserts.sv
// Concurrent checks on the ports of the bit manipulation unit.
`timescale 1ns/1ps
module bmu_core_asserts
    import bmu_pkg::*;
(
    input wire logic              I_CORE_CLK, I_RST_N, I_START, I_IDX_FROM_REG, I_CARRY,
    input wire logic [OP_W-1:0]   I_OP,
    input wire logic [IDX_W-1:0]  I_IMM_IDX,
    input wire logic [DATA_W-1:0] I_OPERAND, I_IDX_REG, O_RESULT,
    input wire logic              O_WRITE, O_CARRY, O_CARRY_WE, O_ZERO, O_ZERO_WE, O_DONE, O_ILLEGAL
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);
    wire [2:0] idx = I_IDX_FROM_REG ? I_IDX_REG[2:0] : I_IMM_IDX;
    wire [7:0] m   = 8'h01 << idx;
    wire       sel = I_OPERAND[idx];
    done_follows_a: assert property (I_START |=> O_DONE)
        else $error("done pulse missing");
    bit_set_a: assert property (I_START && I_OP == BIT_SET_OP
        |=> O_WRITE && O_RESULT == ($past(I_OPERAND) | $past(m))) else $error("set wrong");
    bit_clear_a: assert property (I_START && I_OP == BIT_CLEAR_OP
        |=> O_WRITE && O_RESULT == ($past(I_OPERAND) & ~$past(m))) else $error("clear wrong");
    bit_invert_a: assert property (I_START && I_OP == BIT_INVERT_OP
        |=> O_WRITE && O_RESULT == ($past(I_OPERAND) ^ $past(m))) else $error("invert wrong");
    zero_test_a: assert property (I_START && I_OP == BIT_TEST_OP
        |=> O_ZERO_WE && O_ZERO == !$past(sel)) else $error("zero flag wrong");
    carry_xor_a: assert property (I_START && I_OP == BIT_XOR_CARRY_OP
        |=> O_CARRY_WE && O_CARRY == ($past(I_CARRY) ^ $past(sel))) else $error("xor wrong");
    inv_load_a: assert property (I_START && I_OP == BIT_INV_LOAD_CARRY_OP && !I_IDX_FROM_REG
        |=> O_CARRY_WE && O_CARRY == !$past(sel)) else $error("inverted load wrong");
    store_bit_a: assert property (I_START && I_OP == CARRY_STORE_BIT_OP
        |=> O_WRITE && O_RESULT[$past(idx)] == $past(I_CARRY)) else $error("store wrong");
    read_only_a: assert property (I_START && I_OP inside {[4'h3:4'hb]} |=> !O_WRITE)
        else $error("write on read-only op");
    inv_reg_refused_a: assert property (I_START && I_IDX_FROM_REG && I_OP[0]
        && I_OP inside {[4'h5:4'hd]} |=> O_ILLEGAL && !O_CARRY_WE && !O_WRITE)
        else $error("register index accepted");
endmodule // bmu_core_asserts

bind bmu_core bmu_core_asserts chk (.I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_START(I_START),
    .I_IDX_FROM_REG(I_IDX_FROM_REG), .I_CARRY(I_CARRY), .I_OP(I_OP), .I_IMM_IDX(I_IMM_IDX),
    .I_OPERAND(I_OPERAND), .I_IDX_REG(I_IDX_REG), .O_RESULT(O_RESULT), .O_WRITE(O_WRITE),
    .O_CARRY(O_CARRY), .O_CARRY_WE(O_CARRY_WE), .O_ZERO(O_ZERO), .O_ZERO_WE(O_ZERO_WE),
    .O_DONE(O_DONE), .O_ILLEGAL(O_ILLEGAL));

// >>> sim/testbench.sv
// Self-checking testbench for the bit manipulation unit.
`timescale 1ns/1ps
module testbench;
    import bmu_pkg::*;
    logic       clk = 1'b0, rst_n = 1'b0, start = 1'b0, from_reg = 1'b0, carry = 1'b0;
    logic [3:0] op = 4'h0;
    logic [2:0] imm = 3'h0;
    logic [7:0] operand = 8'h00, idx_reg = 8'h00, res, e;
    logic       wr, c_out, c_we, z, z_we, done, ill, bb;
    int         failures = 0, check_count = 0;
    always #25 clk = ~clk;
    bmu_core DUT (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_START(start), .I_OP(op),
        .I_OPERAND(operand), .I_IDX_FROM_REG(from_reg), .I_IMM_IDX(imm), .I_IDX_REG(idx_reg),
        .I_CARRY(carry), .O_RESULT(res), .O_WRITE(wr), .O_CARRY(c_out), .O_CARRY_WE(c_we),
        .O_ZERO(z), .O_ZERO_WE(z_we), .O_DONE(done), .O_ILLEGAL(ill));
    task automatic cmp8(string what, logic [7:0] exp, logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp1(string what, logic exp, logic got);
        cmp8(what, {7'h00, exp}, {7'h00, got});
    endtask
    // The register index is the inverse of the immediate, so a wrong source shows.
    task automatic go(logic [3:0] o, logic [7:0] d, logic r, logic [2:0] i, logic c);
        @(posedge clk);
        start <= 1'b1;
        op <= o;
        operand <= d;
        from_reg <= r;
        imm <= i;
        idx_reg <= {5'h1f, ~i};
        carry <= c;
        @(posedge clk);
        start <= 1'b0;
        #1;
        cmp1("done", 1'b1, done);
    endtask
    task automatic t_modify();
        for (int k = 0; k < 3; k++) begin
            go(4'(k), 8'h5b, k[0], 3'h7, 1'b0);
            e = k == 0 ? 8'hdb : (k == 1 ? 8'h5a : 8'hdb);
            cmp8("result", e, res);
            cmp1("write", 1'b1, wr);
        end
        $display("test modify done");
    endtask
    task automatic t_carry();
        for (int o = 4; o < 12; o++) begin
            for (int k = 0; k < 4; k++) begin
                go(4'(o), k[1] ? 8'h08 : 8'hf7, 1'b0, 3'h3, k[0]);
                bb = o[0] ? ~k[1] : k[1];
                case (o[3:1])
                    3'h2: e[0] = k[0] & bb;
                    3'h3: e[0] = k[0] | bb;
                    3'h4: e[0] = k[0] ^ bb;
                    default: e[0] = bb;
                endcase
                cmp1("carry", e[0], c_out);
                cmp1("carry_we", 1'b1, c_we);
                cmp1("write", 1'b0, wr);
            end
        end
        $display("test carry done");
    endtask
    task automatic t_test();
        for (int b = 0; b < 2; b++) begin
            go(BIT_TEST_OP, b[0] ? 8'h20 : 8'hdf, 1'b1, 3'h2, 1'b1);
            cmp1("zero", ~b[0], z);
            cmp1("zero_we", 1'b1, z_we);
            cmp1("write", 1'b0, wr);
        end
        $display("test bit test done");
    endtask
    task automatic t_store();
        for (int k = 0; k < 4; k++) begin
            go(k[1] ? INV_CARRY_STORE_BIT_OP : CARRY_STORE_BIT_OP, 8'h3c, 1'b0, 3'h0, k[0]);
            cmp8("result", {7'h1e, k[0] ^ k[1]}, res);
            cmp1("write", 1'b1, wr);
        end
        $display("test store done");
    endtask
    task automatic t_refuse();
        go(BIT_INV_LOAD_CARRY_OP, 8'hff, 1'b1, 3'h0, 1'b0);
        cmp1("illegal", 1'b1, ill);
        cmp1("carry_we", 1'b0, c_we);
        cmp8("result", 8'h3c, res);
        go(4'he, 8'hff, 1'b0, 3'h0, 1'b1);
        cmp1("illegal", 1'b1, ill);
        cmp1("write", 1'b0, wr);
        cmp8("result", 8'h3c, res);
        $display("test refuse done");
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge clk);
        failures++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_modify();
        t_carry();
        t_test();
        t_store();
        t_refuse();
        conclude();
    end
endmodule // testbench
